// >>> bofl_loader.sv
// Boot option and flash lock loader: power-up option byte load
// Overview of operation
// RL1: Options load at power-up only; running code cannot change them.
// RL2: Options live in two flash bytes, programmable and verifiable repeatedly.
// RL3: Program code reads both option bytes through a code table read.
// RL4: Boot bit 7 picks watchdog clock: 0 internal RC, 1 CPU clock.
// RL5: Boot bit 6 high turns the reset pin into a plain input.
// RL6: Boot bit 5 sets port level during reset: 0 low, 1 high.
// RL7: Boot bit 4 picks brownout threshold: 0 high level, 1 low level.
// RL8: Boot bits 1:0 pick CPU clock source; bits 3:2 reserved.
// RL9: Program lock at 0 refuses outside access to program flash, options.
// RL10: Data lock at 0 refuses outside access to data flash, options.
// RL11: Both locks at 1 allow full erase, program and read access.
// RL12: Program lock 0, data lock 1 blocks program area reads only; code refuses every program and option area request.
// RL13: Both locks 0 block both areas; program 1 with data 0 unsupported.
// RL14: Bytes are latched during power-on reset before the CPU is released.
`timescale 1ns/1ps
`default_nettype none
module bofl_loader
  import bofl_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Flash option row read port
  output logic opt_rd_out,
  output logic opt_addr_out,
  input wire logic [7:0] opt_data_in,
  // CPU reset release
  output logic cpu_resetn_out,
  output logic load_done_out,
  // Code-space table read
  input wire logic tbl_rd_in,
  input wire logic [ADDR_W-1:0] tbl_addr_in,
  output logic tbl_hit_out,
  output logic [7:0] tbl_data_out,
  // Option selects
  output logic watchdog_clock_select_out,
  output logic reset_pin_disable_out,
  output logic port_reset_level_out,
  output logic brownout_threshold_select_out,
  output logic osc_select_hi_out,
  output logic osc_select_lo_out,
  output logic osc_reserved_out,
  output logic lock_invalid_out,
  // External programmer access
  input wire logic ext_req_in,
  input wire logic ext_area_data_in,
  input wire logic ext_area_option_in,
  output logic ext_grant_out,
  output logic ext_refuse_out
);
  bofl_state_type state_ff;
  bofl_state_type nxt_state;
  logic [1:0] wait_ff;
  logic [1:0] nxt_wait;
  logic load_boot;
  logic load_lock;
  logic [7:0] boot_byte;
  logic [7:0] lock_byte;
  logic [7:0] tbl_data_ff;
  logic tbl_hit_ff;
  logic cpu_resetn_ff;
  logic lat_done;

  // Load sequence: read boot byte, then lock byte, then release
  always_comb begin
    nxt_state = state_ff;
    nxt_wait = wait_ff;
    unique case (state_ff)
      BOFL_ST_IDLE: begin
        nxt_state = BOFL_ST_RD_BOOT;
      end
      BOFL_ST_RD_BOOT: begin
        nxt_state = BOFL_ST_WT_BOOT;
        nxt_wait = BOFL_RD_LAT;
      end
      BOFL_ST_WT_BOOT: begin
        nxt_wait = wait_ff - 2'h1;
        if (lat_done) begin
          nxt_state = BOFL_ST_RD_LOCK;
        end
      end
      BOFL_ST_RD_LOCK: begin
        nxt_state = BOFL_ST_WT_LOCK;
        nxt_wait = BOFL_RD_LAT;
      end
      BOFL_ST_WT_LOCK: begin
        nxt_wait = wait_ff - 2'h1;
        if (lat_done) begin
          nxt_state = BOFL_ST_DONE;
        end
      end
      BOFL_ST_DONE: begin
        nxt_state = BOFL_ST_DONE; // RL1
      end
      default: begin
        nxt_state = BOFL_ST_IDLE;
      end
    endcase
  end

  assign lat_done = (wait_ff == 2'h1);

  // State and latency counter
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= BOFL_ST_IDLE;
      wait_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
    end
  end

  // Flash reads issued only by the loader, never by software
  assign opt_rd_out = (state_ff == BOFL_ST_RD_BOOT) ||
                      (state_ff == BOFL_ST_RD_LOCK);
  assign opt_addr_out = (state_ff == BOFL_ST_RD_LOCK) ||
                        (state_ff == BOFL_ST_WT_LOCK) ?
                        BOFL_ADDR_LOCK : BOFL_ADDR_BOOT; // RL2
  assign load_boot = (state_ff == BOFL_ST_WT_BOOT) && lat_done; // RL14
  assign load_lock = (state_ff == BOFL_ST_WT_LOCK) && lat_done; // RL14

  // Boot option latch; reserved bits forced to zero
  bofl_hold_latch #(
    .WIDTH(8),
    .RESET_VAL(BOFL_BOOT_RESET & BOFL_BOOT_MASK)
  ) u_boot_latch (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .load_in(load_boot),
    .data_in(opt_data_in & BOFL_BOOT_MASK),
    .data_out(boot_byte)
  );

  // Lock latch; erased value holds both lock bits at 1 until loaded
  bofl_hold_latch #(
    .WIDTH(8),
    .RESET_VAL(BOFL_LOCK_RESET & BOFL_LOCK_MASK)
  ) u_lock_latch (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .load_in(load_lock),
    .data_in(opt_data_in & BOFL_LOCK_MASK),
    .data_out(lock_byte)
  );

  // CPU held in reset until both bytes are latched
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cpu_resetn_ff <= 1'b0;
    end else begin
      cpu_resetn_ff <= (state_ff == BOFL_ST_DONE); // RL14
    end
  end
  assign cpu_resetn_out = cpu_resetn_ff;
  assign load_done_out = (state_ff == BOFL_ST_DONE);

  // Option selects straight from the latches
  assign watchdog_clock_select_out = boot_byte[BOFL_BIT_WDT_CLK]; // RL4
  assign reset_pin_disable_out = boot_byte[BOFL_BIT_RST_PIN_DIS]; // RL5
  assign port_reset_level_out = boot_byte[BOFL_BIT_PORT_LVL]; // RL6
  assign brownout_threshold_select_out = boot_byte[BOFL_BIT_BOR_SEL]; // RL7
  assign osc_select_hi_out = boot_byte[BOFL_BIT_OSC_HI]; // RL8
  assign osc_select_lo_out = boot_byte[BOFL_BIT_OSC_LO]; // RL8
  // Flag the reserved source so clock logic can fall back safely
  assign osc_reserved_out = (boot_byte[1:0] == BOFL_OSC_RSVD); // RL8
  // Unsupported lock pair: program open with data shut
  assign lock_invalid_out = lock_byte[BOFL_BIT_PROG_LOCK] &
                            ~lock_byte[BOFL_BIT_DATA_LOCK]; // RL13

  // Table read: registered data, zero when the address misses
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tbl_data_ff <= 8'h00;
      tbl_hit_ff <= 1'b0;
    end else if (tbl_rd_in) begin
      if (tbl_addr_in == BOFL_TBL_BOOT[ADDR_W-1:0]) begin
        tbl_data_ff <= boot_byte; // RL3
        tbl_hit_ff <= 1'b1;
      end else if (tbl_addr_in == BOFL_TBL_LOCK[ADDR_W-1:0]) begin
        tbl_data_ff <= lock_byte; // RL3
        tbl_hit_ff <= 1'b1;
      end else begin
        tbl_data_ff <= 8'h00;
        tbl_hit_ff <= 1'b0;
      end
    end else begin
      tbl_hit_ff <= 1'b0;
    end
  end
  assign tbl_data_out = tbl_data_ff;
  assign tbl_hit_out = tbl_hit_ff;

  // Programmer gate; nothing granted before the locks are loaded
  bofl_prog_gate u_gate (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .valid_in(state_ff == BOFL_ST_DONE),
    .program_flash_lock_in(lock_byte[BOFL_BIT_PROG_LOCK]),
    .data_flash_lock_in(lock_byte[BOFL_BIT_DATA_LOCK]),
    .req_in(ext_req_in),
    .area_data_in(ext_area_data_in),
    .area_option_in(ext_area_option_in),
    .grant_out(ext_grant_out),
    .refuse_out(ext_refuse_out)
  );
endmodule // bofl_loader
`default_nettype wire

// >>> bofl_pkg.sv
// Package: constants for the boot option and flash lock loader
package bofl_pkg;
  // Option byte addresses in the flash option row
  localparam logic [0:0] BOFL_ADDR_BOOT = 1'h0;
  localparam logic [0:0] BOFL_ADDR_LOCK = 1'h1;
  // Boot option byte field positions
  localparam int BOFL_BIT_WDT_CLK = 7;
  localparam int BOFL_BIT_RST_PIN_DIS = 6;
  localparam int BOFL_BIT_PORT_LVL = 5;
  localparam int BOFL_BIT_BOR_SEL = 4;
  localparam int BOFL_BIT_OSC_HI = 1;
  localparam int BOFL_BIT_OSC_LO = 0;
  // Lock byte field positions
  localparam int BOFL_BIT_PROG_LOCK = 7;
  localparam int BOFL_BIT_DATA_LOCK = 6;
  // Latch values before load: erased flash reads all ones
  localparam logic [7:0] BOFL_BOOT_RESET = 8'hFF;
  localparam logic [7:0] BOFL_LOCK_RESET = 8'hFF;
  // Reserved boot bits 3:2 read back as zero
  localparam logic [7:0] BOFL_BOOT_MASK = 8'hF3;
  localparam logic [7:0] BOFL_LOCK_MASK = 8'hC0;
  // Flash read latency in cycles
  localparam logic [1:0] BOFL_RD_LAT = 2'h2;
  // Code-space table read addresses of the option bytes
  localparam logic [15:0] BOFL_TBL_BOOT = 16'hFFF0;
  localparam logic [15:0] BOFL_TBL_LOCK = 16'hFFF1;
  // Oscillator source codes
  typedef enum logic [1:0] {
    BOFL_OSC_CRYSTAL = 2'b00,
    BOFL_OSC_RC = 2'b01,
    BOFL_OSC_RSVD = 2'b10,
    BOFL_OSC_EXT = 2'b11
  } bofl_osc_type;
  // Loader states
  typedef enum logic [2:0] {
    BOFL_ST_IDLE = 3'b000,
    BOFL_ST_RD_BOOT = 3'b001,
    BOFL_ST_WT_BOOT = 3'b010,
    BOFL_ST_RD_LOCK = 3'b011,
    BOFL_ST_WT_LOCK = 3'b100,
    BOFL_ST_DONE = 3'b101
  } bofl_state_type;
endpackage

// >>> bofl_hold_latch.sv
// Holding latch for one option byte, loaded once per power-on reset
`timescale 1ns/1ps
`default_nettype none
module bofl_hold_latch #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);
  logic [WIDTH-1:0] hold_ff;
  // Capture only on load; nothing else can write it
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hold_ff <= RESET_VAL;
    end else if (load_in) begin
      hold_ff <= data_in;
    end
  end
  assign data_out = hold_ff;
endmodule // bofl_hold_latch
`default_nettype wire

// >>> bofl_prog_gate.sv
// External programmer access gate driven by the lock bits
`timescale 1ns/1ps
`default_nettype none
module bofl_prog_gate (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic valid_in,
  input wire logic program_flash_lock_in,
  input wire logic data_flash_lock_in,
  input wire logic req_in,
  input wire logic area_data_in,
  input wire logic area_option_in,
  output logic grant_out,
  output logic refuse_out
);
  logic allow;
  // Zero lock bit shuts its area and the option bytes
  always_comb begin
    if (!valid_in) begin
      allow = 1'b0;
    end else if (area_option_in) begin
      allow = program_flash_lock_in & data_flash_lock_in; // RL9 RL10
    end else if (area_data_in) begin
      allow = data_flash_lock_in; // RL10 RL12 RL13
    end else begin
      allow = program_flash_lock_in; // RL9 RL12 RL13
    end
  end
  logic grant_ff;
  logic refuse_ff;
  // Registered answer, one cycle after the request
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      grant_ff <= 1'b0;
      refuse_ff <= 1'b0;
    end else begin
      grant_ff <= req_in & allow; // RL11
      refuse_ff <= req_in & ~allow;
    end
  end
  assign grant_out = grant_ff;
  assign refuse_out = refuse_ff;
endmodule // bofl_prog_gate
`default_nettype wire

// >>> bofl_loader_monitor.sv
// Checker for the option loader ports
`timescale 1ns/1ps
`default_nettype none
module bofl_loader_monitor
  import bofl_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic opt_rd_out,
  input wire logic opt_addr_out,
  input wire logic cpu_resetn_out,
  input wire logic load_done_out,
  input wire logic tbl_rd_in,
  input wire logic [ADDR_W-1:0] tbl_addr_in,
  input wire logic tbl_hit_out,
  input wire logic [7:0] tbl_data_out,
  input wire logic watchdog_clock_select_out,
  input wire logic reset_pin_disable_out,
  input wire logic port_reset_level_out,
  input wire logic brownout_threshold_select_out,
  input wire logic osc_select_hi_out,
  input wire logic osc_select_lo_out,
  input wire logic osc_reserved_out,
  input wire logic ext_req_in,
  input wire logic ext_grant_out,
  input wire logic ext_refuse_out
);
  logic [5:0] sel;
  // All option selects as one word, boot byte order
  assign sel = {watchdog_clock_select_out, reset_pin_disable_out,
    port_reset_level_out, brownout_threshold_select_out,
    osc_select_hi_out, osc_select_lo_out};
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  sequence boot_rd_s;
    opt_rd_out && !opt_addr_out;
  endsequence
  sequence lock_rd_s;
    opt_rd_out && opt_addr_out;
  endsequence
  load_order_a: assert property (boot_rd_s |-> ##3 lock_rd_s ##3
    load_done_out ##1 cpu_resetn_out) else $error("load sequence wrong");
  cpu_hold_a: assert property (cpu_resetn_out |-> load_done_out)
    else $error("cpu released before load");
  opts_frozen_a: assert property (load_done_out && $past(load_done_out)
    |-> $stable(sel)) else $error("option changed after load");
  boot_read_a: assert property (tbl_rd_in && load_done_out &&
    tbl_addr_in == BOFL_TBL_BOOT |=> tbl_hit_out &&
    tbl_data_out == {sel[5:2], 2'h0, sel[1:0]}) else $error("boot read bad");
  lock_read_a: assert property (tbl_rd_in && tbl_addr_in == BOFL_TBL_LOCK
    |=> tbl_hit_out && tbl_data_out[5:0] == 6'h00) else $error("lock read bad");
  tbl_miss_a: assert property (tbl_rd_in && tbl_addr_in != BOFL_TBL_BOOT &&
    tbl_addr_in != BOFL_TBL_LOCK |=> !tbl_hit_out && tbl_data_out == 8'h00)
    else $error("table miss bad");
  osc_rsvd_a: assert property (osc_reserved_out ==
    (osc_select_hi_out && !osc_select_lo_out)) else $error("osc flag bad");
  early_refuse_a: assert property (ext_req_in && !load_done_out
    |=> ext_refuse_out && !ext_grant_out) else $error("early access");
  ext_answer_a: assert property (ext_req_in |=> ext_grant_out != ext_refuse_out)
    else $error("no single answer");
  ext_quiet_a: assert property (!ext_req_in |=> !ext_grant_out &&
    !ext_refuse_out) else $error("answer without request");
endmodule // bofl_loader_monitor
bind bofl_loader bofl_loader_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);
`default_nettype wire

// >>> bofl_flash_model.sv
// Flash option row model answering the loader read strobe
`timescale 1ns/1ps
`default_nettype none
module bofl_flash_model (
  input wire logic mclk_in,
  input wire logic rd_in,
  input wire logic addr_in,
  input wire logic [7:0] boot_in,
  input wire logic [7:0] lock_in,
  output logic [7:0] data_out
);
  logic [1:0] wait_ff = 2'h0;
  logic addr_ff = 1'b0;
  logic [7:0] last_ff = 8'h00;
  // Read opens a two cycle data window
  always_ff @(posedge mclk_in) begin
    if (rd_in) begin
      wait_ff <= 2'h2;
      addr_ff <= addr_in;
    end else if (wait_ff != 2'h0) begin
      wait_ff <= wait_ff - 2'h1;
    end
    last_ff <= data_out;
  end
  // Outside the window data toggles, so a late sample shows up
  always_comb begin
    if (wait_ff != 2'h0) begin
      data_out = addr_ff ? lock_in : boot_in;
    end else begin
      data_out = ~last_ff;
    end
  end
endmodule // bofl_flash_model
`default_nettype wire

// >>> test_bofl_loader.sv
// Self-checking bench for the option loader
`timescale 1ns/1ps
`default_nettype none
module test_bofl_loader;
  import bofl_pkg::*;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic tbl_rd_in = 1'b0;
  logic ext_req_in = 1'b0;
  logic ext_area_data_in = 1'b0;
  logic ext_area_option_in = 1'b0;
  logic [15:0] tbl_addr_in = 16'h0000;
  logic [7:0] boot_b = 8'hFF;
  logic [7:0] lock_b = 8'hFF;
  logic [7:0] opt_data_in, tbl_data_out;
  logic opt_rd_out, opt_addr_out, cpu_resetn_out, load_done_out, tbl_hit_out;
  logic watchdog_clock_select_out, reset_pin_disable_out, port_reset_level_out;
  logic brownout_threshold_select_out, osc_select_hi_out, osc_select_lo_out;
  logic osc_reserved_out, lock_invalid_out, ext_grant_out, ext_refuse_out;
  logic [7:0] boot_seen;
  logic [7:0] boots [4] = '{8'hFC, 8'h01, 8'hAE, 8'h53};
  logic [7:0] locks [4] = '{8'hFF, 8'h7F, 8'hBF, 8'h3F};
  int err_total = 0;
  int compares = 0;
  int n;
  // Clock
  always #20 mclk_in = ~mclk_in;
  // Option selects packed back into boot byte order
  assign boot_seen = {watchdog_clock_select_out, reset_pin_disable_out,
    port_reset_level_out, brownout_threshold_select_out, 2'h0,
    osc_select_hi_out, osc_select_lo_out};
  bofl_loader u_dut (.*);
  bofl_flash_model u_flash (.mclk_in(mclk_in), .rd_in(opt_rd_out),
    .addr_in(opt_addr_out), .boot_in(boot_b), .lock_in(lock_b),
    .data_out(opt_data_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One table read, answer sampled a cycle later
  task automatic tbl_read(input logic [15:0] a, input logic h,
    input logic [7:0] d);
    @(posedge mclk_in);
    #1 tbl_rd_in = 1'b1;
    tbl_addr_in = a;
    @(posedge mclk_in);
    #1 tbl_rd_in = 1'b0;
    check({tbl_hit_out, 7'h00}, {h, 7'h00});
    check(tbl_data_out, d);
  endtask
  // One programmer request; expects grant or refusal
  task automatic ext_access(input logic dat, input logic opt, input logic g);
    @(posedge mclk_in);
    #1 ext_req_in = 1'b1;
    ext_area_data_in = dat;
    ext_area_option_in = opt;
    @(posedge mclk_in);
    #1 ext_req_in = 1'b0;
    check({6'h00, ext_grant_out, ext_refuse_out}, {6'h00, g, !g});
  endtask
  // Power-up with fresh flash contents; counts edges to CPU release
  task automatic power_up(input logic [7:0] b, input logic [7:0] l);
    boot_b = b;
    lock_b = l;
    resetn_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    // Still in reset: pre-load latch values, CPU held, table idle
    check(boot_seen, BOFL_BOOT_RESET & BOFL_BOOT_MASK);
    check({7'h00, cpu_resetn_out}, 8'h00);
    check({7'h00, lock_invalid_out}, 8'h00);
    check(tbl_data_out, 8'h00);
    #1 resetn_in = 1'b1;
    ext_access(1'b1, 1'b1, 1'b0);
    n = 2;
    while (cpu_resetn_out !== 1'b1 && n < 20) begin
      @(posedge mclk_in);
      #1 n++;
    end
    check(8'(n), 8'h08);
    check({7'h00, load_done_out}, 8'h01);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog, far beyond the 140 or so cycles the tests need
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
  // Each case covers one oscillator code and one lock pattern
  initial begin
    for (int i = 0; i < 4; i++) begin
      power_up(boots[i], locks[i]);
      check(boot_seen, boots[i] & BOFL_BOOT_MASK);
      check({7'h00, osc_reserved_out}, {7'h00, boots[i][1:0] == 2'b10});
      check({7'h00, lock_invalid_out}, {7'h00, locks[i][7:6] == 2'b10});
      tbl_read(BOFL_TBL_BOOT, 1'b1, boots[i] & BOFL_BOOT_MASK);
      tbl_read(BOFL_TBL_LOCK, 1'b1, locks[i] & BOFL_LOCK_MASK);
      tbl_read(16'h0123, 1'b0, 8'h00);
      ext_access(1'b0, 1'b0, locks[i][7]);
      ext_access(1'b1, 1'b0, locks[i][6]);
      ext_access(1'b0, 1'b1, &locks[i][7:6]);
      // Flash rewritten while running must not reach the selects
      boot_b = ~boots[i];
      repeat (10) @(posedge mclk_in);
      tbl_read(BOFL_TBL_BOOT, 1'b1, boots[i] & BOFL_BOOT_MASK);
      check(boot_seen, boots[i] & BOFL_BOOT_MASK);
      $display("test %0d done", i);
    end
    report_and_stop();
  end
endmodule // test_bofl_loader
`default_nettype wire
